// ### rtl/mtdl_defs.svh
`ifndef MTDL_DEFS_SVH
`define MTDL_DEFS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define MTDL_OFF_CTRL 8'h00
`define MTDL_OFF_STAT 8'h04
`define MTDL_OFF_CNT 8'h08
`define MTDL_OFF_MODE 8'h0C

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define MTDL_CTRL_RUN 0
`define MTDL_CTRL_RST 1'h1
`define MTDL_STAT_NEMP 0
`define MTDL_STAT_FULL 1
`define MTDL_WORD_ZERO 32'h0000_0000
`define MTDL_CNT_ONE 32'h0000_0001

// ----------------------------------------
// Bus response codes
// ----------------------------------------
`define MTDL_RESP_OKAY 2'h0
`define MTDL_RESP_DECERR 2'h3

`endif

// ### rtl/mtdl_pkg.sv
`include "mtdl_defs.svh"

package mtdl_pkg;

  // Bus response on B and R channels
  typedef enum logic [1:0] {
    MTDL_OKAY = `MTDL_RESP_OKAY,
    MTDL_DECERR = `MTDL_RESP_DECERR
  } mtdl_resp_t;

  // One register word
  typedef logic [31:0] mtdl_word_t;

endpackage : mtdl_pkg

// ### rtl/mtdl_top.sv
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "mtdl_defs.svh"
// Functional notes
// - Each enabled rising edge captures the input word into the delay storage. Here only while the run bit is set and the output buffer has room.
// - Tap n shows a captured word after exactly its configured latency.
// - With enable low nothing is captured and every tap holds its value.
// - Reset low clears every storage element of the delay line to zero.
// - With reset wired, storage is built from flip-flops, not small RAM blocks.
// - Mode one allows dual-edge storage per tap; mode zero, the default, rising only. Here MODE only shows in the mode word; every tap stores on the rising edge.
// - Width parameter sets input, tap and storage width; default 32.
// - Tap count parameter sets number of taps; default one.
// - Inputs sampled and outputs changed on the rising clock edge only.
// - Dual-edge mode may pack two taps in one small RAM block.
// - Reset low forces every tap output and all state to zero, except the run bit, which resets to one.

module mtdl_top
  import mtdl_pkg::*;
#(
  parameter int W = 32,
  parameter int N = 1,
  parameter int TAPS [N] = '{default: 1},
  parameter bit [N-1:0] MODE = '0,
  parameter int AW = 8,
  parameter int BUF_DEPTH = 2
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic EN,
  input wire logic [W-1:0] DIN,
  output logic [N*W-1:0] DOUT,
  output logic M_VALID,
  input wire logic M_READY,
  output logic [W-1:0] M_DATA,
  input wire logic [AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  // Last tap is the deepest, so one chain serves every tap
  localparam int DEPTH = TAPS[N-1];
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] FULL_LVL = CW'(BUF_DEPTH);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [W-1:0] chain_ff [DEPTH];
  logic [W-1:0] nxt_chain [DEPTH];
  logic [W-1:0] buf_ff [BUF_DEPTH];
  logic [W-1:0] shift_src [BUF_DEPTH];
  logic [CW-1:0] fill_ff;
  logic [CW-1:0] nxt_fill;
  logic [CW-1:0] slot;
  logic m_valid_ff;
  logic buf_rdy;
  logic adv;
  logic pop;
  logic run_ff;
  mtdl_word_t cnt_ff;
  logic [AW-1:0] awaddr_ff;
  logic aw_held_ff;
  logic awready_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic w_held_ff;
  logic wready_ff;
  logic bvalid_ff;
  mtdl_resp_t bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  mtdl_resp_t rresp_ff;
  mtdl_word_t rdata_ff;
  mtdl_word_t rd_word;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic wr_fire;
  logic b_done;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Word match only: low two address bits are ignored
  function automatic logic mtdl_hit(input logic [AW-1:0] a, input logic [7:0] off);
    return a[AW-1:2] == (AW-2)'(off[7:2]);
  endfunction : mtdl_hit

  function automatic logic mtdl_known(input logic [AW-1:0] a);
    return mtdl_hit(a, `MTDL_OFF_CTRL) || mtdl_hit(a, `MTDL_OFF_STAT) ||
           mtdl_hit(a, `MTDL_OFF_CNT) || mtdl_hit(a, `MTDL_OFF_MODE);
  endfunction : mtdl_known

  // ----------------------------------------
  // Delay chain
  // ----------------------------------------
  // Advance only on enabled, running edges with room downstream
  assign buf_rdy = (fill_ff != FULL_LVL);
  assign adv = RSTN & CE & EN & run_ff & buf_rdy;

  // Each stage takes its neighbour's word; stage zero takes the input
  always_comb begin
    nxt_chain[0] = DIN;
    for (int i = 1; i < DEPTH; i++) begin
      nxt_chain[i] = chain_ff[i-1];
    end
  end

  // Plain flip-flops since reset is always wired; a paused edge moves nothing
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      for (int i = 0; i < DEPTH; i++) begin
        chain_ff[i] <= '0;
      end
    end else if (adv) begin
      chain_ff <= nxt_chain;
    end
  end

  // Each tap is a fixed pick from the chain, W bits wide
  for (genvar n = 0; n < N; n++) begin : g_tap
    assign DOUT[n*W +: W] = chain_ff[TAPS[n]-1];
  end

  // ----------------------------------------
  // Output buffer for the last tap stream
  // ----------------------------------------
  // Each advance pushes the new last-tap word; a full buffer stalls the chain
  assign pop = CE & m_valid_ff & M_READY;
  assign slot = fill_ff - CW'(pop);
  assign nxt_fill = fill_ff + CW'(adv) - CW'(pop);

  // Entry i refills from entry i+1 on a pop; the top entry has no source
  for (genvar i = 0; i < BUF_DEPTH; i++) begin : g_src
    if (i < BUF_DEPTH - 1) begin : g_mid
      assign shift_src[i] = buf_ff[i+1];
    end else begin : g_top
      assign shift_src[i] = '0;
    end
  end

  // Head entry drives the stream straight from a flip-flop
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      fill_ff <= '0;
      m_valid_ff <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_ff[i] <= '0;
      end
    end else if (CE) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        if (adv && slot == CW'(i)) begin
          buf_ff[i] <= nxt_chain[DEPTH-1];
        end else if (pop) begin
          buf_ff[i] <= shift_src[i];
        end
      end
      fill_ff <= nxt_fill;
      m_valid_ff <= (nxt_fill != '0);
    end
  end

  // ----------------------------------------
  // Captured word counter
  // ----------------------------------------
  // Counts chain advances, so software sees how far the line has moved
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      cnt_ff <= `MTDL_WORD_ZERO;
    end else if (adv) begin
      cnt_ff <= cnt_ff + `MTDL_CNT_ONE;
    end
  end

  // ----------------------------------------
  // Bus write path
  // ----------------------------------------
  assign aw_take = CE & S_AXI_AWVALID & awready_ff;
  assign w_take = CE & S_AXI_WVALID & wready_ff;
  assign wr_fire = CE & aw_held_ff & w_held_ff & ~bvalid_ff;
  assign b_done = CE & bvalid_ff & S_AXI_BREADY;

  // Address and data are taken in either order and held until the answer
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      awaddr_ff <= '0;
      aw_held_ff <= 1'b0;
      awready_ff <= 1'b0;
    end else if (CE) begin
      if (aw_take) begin
        awaddr_ff <= S_AXI_AWADDR;
        aw_held_ff <= 1'b1;
        awready_ff <= 1'b0;
      end else if (b_done) begin
        aw_held_ff <= 1'b0;
      end else if (!aw_held_ff && !bvalid_ff) begin
        awready_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      wdata_ff <= '0;
      wstrb_ff <= '0;
      w_held_ff <= 1'b0;
      wready_ff <= 1'b0;
    end else if (CE) begin
      if (w_take) begin
        wdata_ff <= S_AXI_WDATA;
        wstrb_ff <= S_AXI_WSTRB;
        w_held_ff <= 1'b1;
        wready_ff <= 1'b0;
      end else if (b_done) begin
        w_held_ff <= 1'b0;
      end else if (!w_held_ff && !bvalid_ff) begin
        wready_ff <= 1'b1;
      end
    end
  end

  // Response one cycle after both halves are held; unmapped gets DECERR
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= MTDL_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= mtdl_known(awaddr_ff) ? MTDL_OKAY : MTDL_DECERR;
    end else if (b_done) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Run bit gates the chain; read-only words ignore writes
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      run_ff <= `MTDL_CTRL_RST;
    end else if (wr_fire && mtdl_hit(awaddr_ff, `MTDL_OFF_CTRL) && wstrb_ff[0]) begin
      run_ff <= wdata_ff[`MTDL_CTRL_RUN];
    end
  end

  // ----------------------------------------
  // Bus read path
  // ----------------------------------------
  assign ar_take = CE & S_AXI_ARVALID & arready_ff;

  // Read word mux; mode word shows which taps allow dual-edge storage
  always_comb begin
    rd_word = `MTDL_WORD_ZERO;
    if (mtdl_hit(S_AXI_ARADDR, `MTDL_OFF_CTRL)) begin
      rd_word[`MTDL_CTRL_RUN] = run_ff;
    end else if (mtdl_hit(S_AXI_ARADDR, `MTDL_OFF_STAT)) begin
      rd_word[`MTDL_STAT_NEMP] = m_valid_ff;
      rd_word[`MTDL_STAT_FULL] = ~buf_rdy;
    end else if (mtdl_hit(S_AXI_ARADDR, `MTDL_OFF_CNT)) begin
      rd_word = cnt_ff;
    end else if (mtdl_hit(S_AXI_ARADDR, `MTDL_OFF_MODE)) begin
      for (int i = 0; i < N && i < 32; i++) begin
        rd_word[i] = MODE[i];
      end
    end
  end

  // Data registered on the address edge; one read in flight at a time
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= MTDL_OKAY;
      rdata_ff <= `MTDL_WORD_ZERO;
    end else if (CE) begin
      if (ar_take) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_word;
        rresp_ff <= mtdl_known(S_AXI_ARADDR) ? MTDL_OKAY : MTDL_DECERR;
      end else begin
        if (rvalid_ff && S_AXI_RREADY) begin
          rvalid_ff <= 1'b0;
        end
        if (!rvalid_ff && !arready_ff) begin
          arready_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  assign M_VALID = m_valid_ff;
  assign M_DATA = buf_ff[0];
  assign S_AXI_AWREADY = awready_ff;
  assign S_AXI_WREADY = wready_ff;
  assign S_AXI_BVALID = bvalid_ff;
  assign S_AXI_BRESP = bresp_ff;
  assign S_AXI_ARREADY = arready_ff;
  assign S_AXI_RVALID = rvalid_ff;
  assign S_AXI_RRESP = rresp_ff;
  assign S_AXI_RDATA = rdata_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  sequence s_wr_both;
    aw_held_ff && w_held_ff && !bvalid_ff && CE;
  endsequence

  sequence s_ctrl_wr;
    s_wr_both ##0 (mtdl_hit(awaddr_ff, `MTDL_OFF_CTRL) && wstrb_ff[0]);
  endsequence

  a_capture_word: assert property (adv |=> chain_ff[0] == $past(DIN))
    else $error("Input word not captured on enabled edge");

  for (genvar i = 1; i < DEPTH; i++) begin : g_chk
    a_stage_shift: assert property (adv |=> chain_ff[i] == $past(chain_ff[i-1]))
      else $error("Chain stage did not take its neighbour");
  end

  a_hold_idle: assert property (!adv |=> $stable(DOUT) && $stable(chain_ff[0]))
    else $error("Tap changed while paused");

  a_reset_zero: assert property (disable iff (1'b0) !RSTN |=> DOUT == '0 && !M_VALID)
    else $error("Taps not cleared by reset");

  a_reset_chain: assert property (disable iff (1'b0) !RSTN |=> chain_ff[0] == '0 && chain_ff[DEPTH-1] == '0)
    else $error("Storage not cleared by reset");

  a_count_steps: assert property (1'b1 |=> cnt_ff == $past(cnt_ff) + 32'($past(adv)))
    else $error("Advance count mismatch");

  a_stall_full: assert property (fill_ff == FULL_LVL |-> !adv && M_VALID)
    else $error("Chain advanced into a full buffer");

  a_write_resp: assert property (s_wr_both |=> S_AXI_BVALID)
    else $error("Write answer missing");

  a_run_update: assert property (s_ctrl_wr |=> run_ff == $past(wdata_ff[`MTDL_CTRL_RUN]))
    else $error("Run bit not written");

  a_read_answer: assert property (ar_take |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("Read answer missing");

  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("Read data dropped before taken");

endmodule : mtdl_top

// ### verif/mtdl_sink.sv
`timescale 1ns/1ps
// ----
// Stream consumer
// ----
module mtdl_sink (
  input wire logic clk,
  input wire logic [1:0] mode,
  output logic ready
);
  initial ready = 1'b0;
  // Random stalls, and the stopped mode that holds ready low, are what make the two-entry buffer fill up
  always @(posedge clk) begin
    case (mode)
      2'h0: ready <= 1'b1;
      2'h1: ready <= 1'($urandom_range(1));
      default: ready <= 1'b0;
    endcase
  end
endmodule : mtdl_sink

// ### verif/mtdl_top_tb.sv
`timescale 1ns/1ps
module mtdl_top_tb;
  import mtdl_pkg::*;
  localparam int W = 32;
  localparam int N = 3;
  localparam int TP [N] = '{2, 5, 7};
  localparam bit [N-1:0] MD = 3'h2;
  logic clk, rstn, ce, en, mrdy, mval, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, run_m, mon, adv;
  logic [W-1:0] din, mdat, rd, wd;
  logic [N*W-1:0] dout;
  logic [7:0] awa, ara;
  logic [3:0] ws;
  logic [1:0] bresp, rresp, smode;
  logic [W-1:0] ex [TP[N-1]];
  logic [W-1:0] fq [$];
  int fails, checked, cnt;

  mtdl_top #(.W(W), .N(N), .TAPS(TP), .MODE(MD)) u_mtdl_top (
    .CLK_SYS(clk), .RSTN(rstn), .CE(ce), .EN(en), .DIN(din), .DOUT(dout),
    .M_VALID(mval), .M_READY(mrdy), .M_DATA(mdat),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
    .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr)
  );
  mtdl_sink u_mtdl_sink (.clk(clk), .mode(smode), .ready(mrdy));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    awa <= a; wd <= d; ws <= 4'hF; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1 && t++ < 100);
    // A write that never answers counts against the run
    if (bv !== 1'b1) fails++;
    br <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && t++ < 100);
    // A read that never answers counts against the run
    if (rv !== 1'b1) fails++;
    rr <= 1'b0;
    chk(rd, e);
    chk(32'(rresp), 32'(er));
  endtask : axr

  // Status word for a given buffer fill: bit 0 non-empty, bit 1 full
  function automatic logic [31:0] exp_stat(input int fill);
    return {30'h0, fill >= 2, fill > 0};
  endfunction : exp_stat

  // Random words, enable duty in percent, optional random clock-enable drops
  task automatic stream(input int cyc, input logic [1:0] sm, input bit cer, input int enp);
    smode <= sm;
    repeat (cyc) begin
      @(posedge clk);
      din <= $urandom;
      en <= ($urandom_range(99) < enp);
      ce <= !cer || ($urandom_range(7) != 0);
    end
    @(posedge clk);
    en <= 1'b0;
    ce <= 1'b1;
  endtask : stream

  task automatic results();
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results

  // ----
  // Reference model and monitor
  // ----
  // Stall decision uses the fill before any pop, as the buffer does
  always @(posedge clk) begin
    if (!rstn) begin
      ex = '{default: '0};
      fq.delete();
      cnt = 0;
      run_m = 1'b1;
    end else if (ce) begin
      adv = en && run_m && fq.size() < 2;
      if (fq.size() > 0 && mrdy) void'(fq.pop_front());
      if (adv) begin
        for (int i = TP[N-1] - 1; i > 0; i--) ex[i] = ex[i-1];
        ex[0] = din;
        fq.push_back(ex[TP[N-1]-1]);
        cnt++;
      end
    end
  end

  // Outputs are settled by the falling edge
  always @(negedge clk) begin
    if (mon) begin
      for (int n = 0; n < N; n++) chk(dout[n*W +: W], ex[TP[n]-1]);
      chk(32'(mval), 32'(fq.size() > 0));
      if (fq.size() > 0) chk(mdat, fq[0]);
    end
  end

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Watchdog: the run needs about 700 cycles
  initial begin
    #(25 * 20000);
    fails++;
    results();
  end

  // ----
  // Main sequence
  // ----
  initial begin
    rstn = 1'b0; ce = 1'b1; en = 1'b0; din = '0; smode = 2'h0; mon = 1'b0;
    awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = '0; ara = '0; wd = '0; ws = '0; fails = 0; checked = 0;
    void'($urandom(32'h86EF));
    @(posedge clk);
    mon <= 1'b1;
    repeat (7) @(posedge clk);
    rstn <= 1'b1;
    axr(8'h00, 32'h1, 2'h0);
    axr(8'h0C, 32'(MD), 2'h0);
    axr(8'h10, 32'h0, 2'h3);
    $display("test registers done");
    stream(30, 2'h0, 1'b0, 100);
    stream(400, 2'h1, 1'b1, 75);
    $display("test random stream done");
    stream(20, 2'h2, 1'b0, 100);
    axr(8'h04, exp_stat(2), 2'h0);
    stream(10, 2'h0, 1'b0, 0);
    axr(8'h04, exp_stat(0), 2'h0);
    axr(8'h08, 32'(cnt), 2'h0);
    $display("test full buffer done");
    axw(8'h00, 32'h0, 2'h0);
    run_m <= 1'b0;
    stream(40, 2'h1, 1'b0, 100);
    axr(8'h00, 32'h0, 2'h0);
    axw(8'h00, 32'h1, 2'h0);
    run_m <= 1'b1;
    axw(8'h04, 32'hFFFF_FFFF, 2'h0);
    axw(8'h20, 32'h0, 2'h3);
    axr(8'h08, 32'(cnt), 2'h0);
    $display("test run control done");
    stream(50, 2'h1, 1'b0, 100);
    @(posedge clk);
    rstn <= 1'b0;
    en <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    en <= 1'b0;
    stream(50, 2'h0, 1'b0, 100);
    axr(8'h00, 32'h1, 2'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule : mtdl_top_tb
